// ### bench/cbs_core_chk.sv
// port assertions for the hazard unit
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module cbs_core_chk (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_valid,
	input wire logic [31:0] i_instr,
	input wire logic [31:0] i_instr_addr,
	input wire logic [1:0] i_mode,
	input wire logic [31:0] i_pc_psr,
	input wire logic i_variant_two,
	input wire logic i_data_abort,
	input wire logic i_prefetch_abort,
	input wire logic [1:0] o_rf_bank,
	input wire logic [1:0] o_xfer_bank,
	input wire logic o_bank_hazard,
	input wire logic [31:0] o_base_value,
	input wire logic o_base_wb_en,
	input wire logic [1:0] o_base_wb_bank,
	input wire logic o_pc_write_en,
	input wire logic o_flags_write,
	input wire logic o_mul_corrupt,
	input wire logic o_trap_take,
	input wire logic [31:0] o_trap_vector,
	input wire logic [31:0] o_fault_addr
);
	wire logic ex = i_valid && i_instr[31:28] != 4'hF;
	wire logic blk = ex && i_instr[27:25] == 3'h4;
	wire logic mul = ex && i_instr[27:22] == 6'h0 && i_instr[7:4] == 4'h9;
	wire logic frc = blk && i_instr[22] && !i_instr[15] && i_mode != 2'h0;
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);
	// ****************
	// assertions
	// ****************
	bank_lag_a: assert property (
		frc && i_instr[20] |=> o_bank_hazard && o_rf_bank == 2'h0)
		else $error("bank lag missing");
	user_wb_a: assert property (
		frc && i_instr[21] |=> o_base_wb_en && o_base_wb_bank == 2'h0)
		else $error("write-back bank wrong");
	pc_list_a: assert property (
		blk && i_instr[22] && i_instr[20] && i_instr[15] |-> o_xfer_bank == i_mode)
		else $error("pc in list still forced");
	swtrap_vec_a: assert property (
		ex && i_instr[27:24] == 4'hF && i_variant_two && !i_prefetch_abort && !i_data_abort
		|-> ##1 o_trap_take && o_trap_vector == 32'h8) else $error("sw trap vector");
	abort_first_a: assert property (
		i_valid && i_prefetch_abort && !i_data_abort |=> o_trap_take
		&& o_trap_vector == 32'hC && o_fault_addr == $past(i_instr_addr)) else $error("abort");
	mul_pc_a: assert property (
		mul && i_instr[19:16] == 4'hF |=> !o_pc_write_en && o_flags_write == $past(i_instr[20]))
		else $error("multiply wrote pc");
	mul_bad_a: assert property (
		mul |=> o_mul_corrupt == ($past(i_instr[19:16]) == $past(i_instr[3:0])))
		else $error("multiply corrupt flag");
	blk_base_a: assert property (
		blk && i_instr[19:16] == 4'hF |=> o_base_value == $past(i_pc_psr))
		else $error("block base wrong");
	mode_lag_a: assert property (
		ex && i_mode != 2'h0 && i_instr[27:26] == 2'h0 && i_instr[24:23] == 2'h2
		&& i_instr[20] && i_instr[15:12] == 4'hF |=> o_bank_hazard && o_rf_bank == $past(i_mode))
		else $error("mode change lag missing");
	cop_wb_a: assert property (
		ex && i_instr[27:25] == 3'h6 && i_instr[19:16] == 4'hF |=> !o_base_wb_en)
		else $error("coprocessor pc write-back");
endmodule

bind cbs_core cbs_core_chk chk (.*);

// ### bench/tb_cbs_core.sv
// self-checking bench for the hazard unit
// assumes cbs_defines.svh on the include path
`timescale 1ns/1ps
`include "cbs_defines.svh"
module tb_cbs_core;
	logic i_mclk, i_rst, i_valid, i_variant_two, i_late_abort;
	logic i_data_abort, i_prefetch_abort, i_cop_swi_glitch, tv;
	logic [1:0] i_mode, o_rf_bank, o_xfer_bank, o_base_wb_bank;
	logic [31:0] i_instr, i_instr_addr, i_pc_psr, i_reg_first, i_reg_second, i_reg_shift;
	logic o_bank_hazard, o_base_wb_en, o_pc_write_en, o_flags_write;
	logic o_mul_corrupt, o_swap_op, o_trap_take;
	logic [31:0] o_op_first, o_op_second, o_op_shift, o_base_value, o_trap_vector, o_fault_addr;
	logic [31:0] pp, ia, ra, rb, rc;
	int err_count, num_checks, cyc, nid, in_id, tid;
	typedef struct {int id; int s; logic [31:0] m; logic [31:0] e;} cbs_note_t;
	cbs_note_t q[$];
	wire logic [223:0] ov = {o_fault_addr, o_op_first, o_op_second, o_op_shift, o_base_value,
		o_trap_vector, 21'h0, o_bank_hazard, o_rf_bank, o_base_wb_en, o_base_wb_bank,
		o_pc_write_en, o_flags_write, o_mul_corrupt, o_swap_op, o_trap_take};
	cbs_core dut (.*);
	// ****************
	// clock, timeout and result watcher
	// ****************
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk) begin
		tv <= i_valid;
		tid <= in_id;
		cyc <= cyc + 1;
		if (cyc > 400) begin
			err_count++;
			test_done();
		end
	end
	always @(negedge i_mclk) begin
		while (q.size() > 0 && tv === 1'b1 && q[0].id == tid) begin
			cbs_note_t h;
			h = q.pop_front();
			num_checks++;
			if ((ov[h.s * 32 +: 32] & h.m) !== h.e) begin
				err_count++;
				$display("unexpected at %0t got %h expected %h", $time, ov[h.s * 32 +: 32] & h.m, h.e);
			end
		end
	end
	// ****************
	// drivers
	// ****************
	task automatic issue(input logic [31:0] ins, input logic [1:0] md, input logic [4:0] c);
		@(posedge i_mclk);
		{pp, ia, ra, rb, rc} = {$urandom(), $urandom(), $urandom(), $urandom(), $urandom()};
		nid++;
		in_id <= nid;
		i_valid <= 1'b1;
		i_instr <= ins;
		i_mode <= md;
		{i_variant_two, i_late_abort, i_cop_swi_glitch, i_data_abort, i_prefetch_abort} <= c;
		{i_pc_psr, i_instr_addr, i_reg_first, i_reg_second, i_reg_shift} <= {pp, ia, ra, rb, rc};
	endtask
	task automatic note(input int s, input logic [31:0] m, input logic [31:0] e);
		q.push_back('{nid, s, m, e});
	endtask
	task automatic trap(input logic [31:0] ins, input logic [4:0] c, input logic [31:0] v);
		issue(ins, 2'h3, c);
		note(0, 32'h1, 32'h1);
		note(1, '1, v);
	endtask
	task automatic test_done();
		if (err_count == 0 && num_checks > 0 && q.size() == 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// ****************
	// sequence
	// ****************
	initial begin
		{i_rst, i_valid, i_variant_two, i_late_abort, i_data_abort} = 5'h10;
		{i_prefetch_abort, i_cop_swi_glitch, i_mode, i_instr} = '0;
		{i_instr_addr, i_pc_psr, i_reg_first, i_reg_second, i_reg_shift} = '0;
		void'($urandom(32'h77F4));
		repeat (20) @(posedge i_mclk);
		i_rst <= 1'b0;
		issue(32'hE8F400FF, 2'h3, 5'h10);
		note(0, 32'h7E0, 32'h480);
		issue(32'hE0810312, 2'h2, 5'h10);
		note(5, '1, ra);
		note(0, 32'h700, 32'h300);
		issue(32'hE33FF000, 2'h3, 5'h10);
		note(0, 32'h718, 32'h708);
		issue(32'hE08F0F1F, 2'h0, 5'h10);
		note(5, '1, pp & `CBS_PC_MASK);
		note(4, '1, pp);
		note(3, '1, pp & `CBS_PC_MASK);
		issue(32'hE8D48001, 2'h3, 5'h10);
		note(0, 32'h400, 32'h0);
		issue(32'hE89F0003, 2'h3, 5'h10);
		note(2, '1, pp);
		issue(32'hE791000F, 2'h3, 5'h10);
		note(4, '1, pp);
		issue(32'hE01F0291, 2'h3, 5'h10);
		note(0, 32'h1C, 32'h8);
		issue(32'hE0110291, 2'h3, 5'h10);
		note(0, 32'h1C, 32'hC);
		issue(32'hEDBF0100, 2'h3, 5'h10);
		note(0, 32'h80, 32'h0);
		issue(32'hE5A10004, 2'h3, 5'h1A);
		note(0, 32'h81, 32'h81);
		issue(32'hE1020091, 2'h3, 5'h10);
		note(0, 32'h3, 32'h2);
		issue(32'hFF000011, 2'h3, 5'h10);
		note(0, 32'h1, 32'h0);
		trap(32'hEF000011, 5'h10, `CBS_VEC_SWTRAP);
		trap(32'hE6100010, 5'h10, `CBS_VEC_UNDEF);
		trap(32'hE6100010, 5'h11, `CBS_VEC_PREFETCH);
		note(6, '1, ia);
		trap(32'hE1020091, 5'h00, `CBS_VEC_UNDEF);
		trap(32'hE5B10000, 5'h13, `CBS_VEC_DATA);
		note(0, 32'h80, 32'h0);
		issue(32'hEE000000, 2'h3, 5'h04);
		trap(32'hEF000011, 5'h04, `CBS_VEC_UNDEF);
		trap(32'hEF000011, 5'h04, `CBS_VEC_SWTRAP);
		@(posedge i_mclk);
		i_valid <= 1'b0;
		repeat (3) @(posedge i_mclk);
		test_done();
	end
endmodule

// ### core/cbs_core.sv
// bank-switch, trap and pc-operand hazard unit of a 26-bit core
// assumes one instruction presented per cycle with its operands read
//
// Functional notes
// RULE1 - bank returns from user one cycle late
// RULE2 - unbanked registers and pc always correct
// RULE3 - pc in list cancels user-bank forcing (code cancels it for loads only; stores with pc in list stay forced)
// RULE4 - first variant: trap after coprocessor op may misroute
// RULE5 - software trap vectors to address eight
// RULE6 - prefetch abort beats undefined instruction
// RULE7 - prefetch abort reports undefined instruction address
// RULE8 - software avoids never condition encoding
// RULE9 - multiply into pc changes only flags
// RULE10 - multiply with rd equal rm corrupts result
// RULE11 - pc as register offset gives pc plus status
// RULE12 - late aborts keep single transfer base write-back
// RULE13 - coprocessor transfer never writes pc base
// RULE14 - first variant two undefined, second one
// RULE15 - block transfer pc base uses pc plus status
// RULE16 - in-line mode change lags bank one cycle
// RULE17 - software never byte-transfers the pc
// RULE18 - pc as second operand carries flags, others zero
// RULE19 - forced user block write-back lands in user bank
`timescale 1ns/1ps
`include "cbs_defines.svh"

module cbs_core (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_valid,
	input wire logic [31:0] i_instr,
	input wire logic [31:0] i_instr_addr,
	input wire logic [1:0] i_mode,
	input wire logic [31:0] i_pc_psr,
	input wire logic i_variant_two,
	input wire logic i_late_abort,
	input wire logic i_data_abort,
	input wire logic i_prefetch_abort,
	input wire logic i_cop_swi_glitch,
	input wire logic [31:0] i_reg_first,
	input wire logic [31:0] i_reg_second,
	input wire logic [31:0] i_reg_shift,
	output logic [1:0] o_rf_bank,
	output logic [1:0] o_xfer_bank,
	output logic o_bank_hazard,
	output logic [31:0] o_op_first,
	output logic [31:0] o_op_second,
	output logic [31:0] o_op_shift,
	output logic [31:0] o_base_value,
	output logic o_base_wb_en,
	output logic [1:0] o_base_wb_bank,
	output logic o_pc_write_en,
	output logic o_flags_write,
	output logic o_mul_corrupt,
	output logic o_swap_op,
	output logic o_trap_take,
	output logic [31:0] o_trap_vector,
	output logic [31:0] o_fault_addr
);

	// ****************************************
	// instruction decode
	// ****************************************
	logic [3:0] cond;
	logic [3:0] rn;
	logic [3:0] rd;
	logic [3:0] rm;
	logic [3:0] rs;
	logic exec;
	logic priv;
	logic is_mul;
	logic is_swap_pat;
	logic is_dp;
	logic is_mode_chg;
	logic is_single;
	logic is_single_undef;
	logic is_block;
	logic is_cop_xfer;
	logic is_cop_data;
	logic is_swtrap;
	logic force_user;
	logic is_undef;
	logic bank_lag;
	logic [1:0] lag_bank;
	logic prev_cop_data;
	logic [31:0] pc_bare;
	logic [31:0] next_base_value;

	assign cond = i_instr[31:28];
	assign rn = i_instr[19:16];
	assign rd = i_instr[15:12];
	assign rm = i_instr[3:0];
	assign rs = i_instr[11:8];
	assign exec = i_valid && (cond != `CBS_COND_NEVER); // RULE8
	assign priv = (i_mode != `CBS_MODE_USER);
	assign pc_bare = i_pc_psr & `CBS_PC_MASK;

	assign is_mul = (i_instr[27:22] == 6'h00) && (i_instr[7:4] == 4'h9);
	assign is_swap_pat = (i_instr[27:23] == 5'h02) && (i_instr[21:20] == 2'h0)
		&& (i_instr[11:4] == 8'h09);
	assign is_dp = (i_instr[27:26] == 2'h0) && !is_mul && !is_swap_pat;
	assign is_mode_chg = is_dp && (i_instr[24:23] == 2'h2) && i_instr[20]
		&& (rd == `CBS_REG_PC) && priv;
	assign is_single = (i_instr[27:26] == 2'h1);
	assign is_single_undef = is_single && i_instr[25] && i_instr[4];
	assign is_block = (i_instr[27:25] == 3'h4);
	assign is_cop_xfer = (i_instr[27:25] == 3'h6);
	assign is_cop_data = (i_instr[27:24] == 4'hE) && !i_instr[4];
	assign is_swtrap = (i_instr[27:24] == 4'hF);
	// pc in the list cancels user-bank forcing for loads
	assign force_user = is_block && i_instr[22] && priv
		&& !(i_instr[20] && i_instr[15]); // RULE3
	// second variant turns the swap pattern into a real operation
	assign is_undef = is_single_undef || (is_swap_pat && !i_variant_two); // RULE14

	// ****************************************
	// register bank select
	// ****************************************
	// one cycle of stale bank after forced load or in-line mode change
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			bank_lag <= 1'b0;
			lag_bank <= `CBS_MODE_USER;
		end else if (exec && force_user && i_instr[20]) begin
			bank_lag <= 1'b1; // RULE1
			lag_bank <= `CBS_MODE_USER;
		end else if (exec && is_mode_chg) begin
			bank_lag <= 1'b1; // RULE16
			lag_bank <= i_mode;
		end else begin
			bank_lag <= 1'b0;
			lag_bank <= `CBS_MODE_USER;
		end
	end

	// the lag only steers banked registers; r0-r7 and pc are unbanked
	assign o_rf_bank = bank_lag ? lag_bank : i_mode; // RULE1 RULE16
	assign o_bank_hazard = bank_lag; // RULE2
	assign o_xfer_bank = (exec && force_user) ? `CBS_MODE_USER : i_mode;

	// ****************************************
	// pc as operand or base
	// ****************************************
	always_comb begin
		next_base_value = i_reg_first;
		if ((is_block || is_single) && rn == `CBS_REG_PC) begin
			next_base_value = is_block ? i_pc_psr : pc_bare; // RULE15
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_op_first <= 32'h00000000;
			o_op_second <= 32'h00000000;
			o_op_shift <= 32'h00000000;
			o_base_value <= 32'h00000000;
		end else begin
			o_op_first <= (rn == `CBS_REG_PC) ? pc_bare : i_reg_first; // RULE18
			o_op_second <= (rm == `CBS_REG_PC) ? i_pc_psr : i_reg_second; // RULE18 RULE11
			o_op_shift <= (rs == `CBS_REG_PC) ? pc_bare : i_reg_shift; // RULE18
			o_base_value <= next_base_value;
		end
	end

	// ****************************************
	// write-back control
	// ****************************************
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_base_wb_en <= 1'b0;
			o_base_wb_bank <= `CBS_MODE_USER;
		end else begin
			o_base_wb_bank <= (exec && force_user) ? `CBS_MODE_USER : i_mode; // RULE19
			if (!exec) begin
				o_base_wb_en <= 1'b0;
			end else if (is_single) begin
				o_base_wb_en <= (!i_instr[24] || i_instr[21])
					&& (!i_data_abort || i_late_abort); // RULE12
			end else if (is_block) begin
				o_base_wb_en <= i_instr[21];
			end else if (is_cop_xfer) begin
				o_base_wb_en <= i_instr[21] && (rn != `CBS_REG_PC); // RULE13
			end else begin
				o_base_wb_en <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_pc_write_en <= 1'b0;
			o_flags_write <= 1'b0;
			o_mul_corrupt <= 1'b0;
			o_swap_op <= 1'b0;
		end else begin
			// multiply protects the pc, leaving only flag updates
			o_pc_write_en <= exec && is_dp && !is_mode_chg && (rd == `CBS_REG_PC);
			o_flags_write <= exec && (is_dp || is_mul) && i_instr[20]; // RULE9
			o_mul_corrupt <= exec && is_mul && (rn == rm); // RULE10
			o_swap_op <= exec && is_swap_pat && i_variant_two; // RULE14
		end
	end

	// ****************************************
	// trap requests
	// ****************************************
	cbs_trap_if trap ();

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			prev_cop_data <= 1'b0;
		end else if (i_valid) begin
			prev_cop_data <= exec && is_cop_data;
		end
	end

	assign trap.pend_prefetch = i_valid && i_prefetch_abort; // RULE6
	assign trap.pend_data = exec && i_data_abort && (is_single || is_block || is_cop_xfer);
	assign trap.pend_undef = exec && (is_undef
		|| (is_swtrap && prev_cop_data && !i_variant_two && i_cop_swi_glitch)); // RULE4
	assign trap.pend_swi = exec && is_swtrap;

	cbs_trap_arb u_arb (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.trap(trap)
	);

	// fault address is the instruction's own, even when the next page is absent
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_fault_addr <= 32'h00000000;
		end else if (trap.pend_prefetch) begin
			o_fault_addr <= i_instr_addr; // RULE7
		end
	end

	assign o_trap_take = trap.take;
	assign o_trap_vector = trap.vector;

endmodule

// ### core/cbs_defines.svh
// constants for the bank-switch and trap hazard unit
// assumes a 26-bit address core with pc and status flags in one word
`ifndef CBS_DEFINES_SVH
`define CBS_DEFINES_SVH

// ****************************************
// instruction fields
// ****************************************
`define CBS_COND_NEVER 4'hF
`define CBS_REG_PC 4'hF
`define CBS_PSR_MASK 32'hFC000003
`define CBS_PC_MASK 32'h03FFFFFC

// ****************************************
// exception vectors
// ****************************************
`define CBS_VEC_UNDEF 32'h00000004
`define CBS_VEC_SWTRAP 32'h00000008
`define CBS_VEC_PREFETCH 32'h0000000C
`define CBS_VEC_DATA 32'h00000010

// ****************************************
// modes and banks
// ****************************************
`define CBS_MODE_USER 2'h0
`define CBS_MODE_RESET 2'h3

`endif

// ### core/cbs_pkg.sv
// types for the bank-switch and trap hazard unit
// assumes cbs_defines.svh is on the include path
package cbs_pkg;

	typedef enum logic [2:0] {
		cbs_trap_none_t_v = 3'h0,
		cbs_trap_swi = 3'h1,
		cbs_trap_undef = 3'h3,
		cbs_trap_prefetch = 3'h2,
		cbs_trap_data = 3'h6
	} cbs_trap_t;

	typedef logic [1:0] cbs_mode_t;

endpackage

// ### core/cbs_trap_arb.sv
// trap arbiter: picks the highest priority pending trap
// assumes pending flags are valid for one cycle each
`timescale 1ns/1ps
`include "cbs_defines.svh"

module cbs_trap_arb (
	input wire logic i_mclk,
	input wire logic i_rst,
	cbs_trap_if.arb trap
);

	// ****************************************
	// registered priority pick
	// ****************************************
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			trap.take <= 1'b0;
			trap.kind <= cbs_pkg::cbs_trap_none_t_v;
			trap.vector <= 32'h00000000;
		end else begin
			trap.take <= trap.pend_data | trap.pend_prefetch | trap.pend_undef | trap.pend_swi;
			if (trap.pend_data) begin
				trap.kind <= cbs_pkg::cbs_trap_data;
				trap.vector <= `CBS_VEC_DATA;
			end else if (trap.pend_prefetch) begin
				trap.kind <= cbs_pkg::cbs_trap_prefetch; // RULE6
				trap.vector <= `CBS_VEC_PREFETCH;
			end else if (trap.pend_undef) begin
				trap.kind <= cbs_pkg::cbs_trap_undef;
				trap.vector <= `CBS_VEC_UNDEF;
			end else if (trap.pend_swi) begin
				trap.kind <= cbs_pkg::cbs_trap_swi;
				trap.vector <= `CBS_VEC_SWTRAP; // RULE5
			end else begin
				trap.kind <= cbs_pkg::cbs_trap_none_t_v;
				trap.vector <= 32'h00000000;
			end
		end
	end

endmodule

// ### core/cbs_trap_if.sv
// carrier between the hazard unit and its trap arbiter
// assumes one clock shared by both ends
`timescale 1ns/1ps

interface cbs_trap_if;
	logic pend_prefetch;
	logic pend_undef;
	logic pend_swi;
	logic pend_data;
	logic take;
	cbs_pkg::cbs_trap_t kind;
	logic [31:0] vector;

	modport src (
		output pend_prefetch,
		output pend_undef,
		output pend_swi,
		output pend_data,
		input take,
		input kind,
		input vector
	);

	modport arb (
		input pend_prefetch,
		input pend_undef,
		input pend_swi,
		input pend_data,
		output take,
		output kind,
		output vector
	);
endinterface
